// ### xid_datapath.sv
// exclusive-OR execution datapath: immediate and file-register forms
// assumes decode presents a program word held through the phase-1 enable
// and that the file register read data is combinational on file_addr
`timescale 1ns/1ps
module xid_datapath
    import xid_pkg::*;
#(
    parameter int CLKS_PER_PHASE = XID_CLKS_PER_PHASE
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // instruction from decode
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    // file register access
    output logic [6:0] file_addr,
    output logic file_rd_en,
    input wire logic [7:0] file_rdata,
    output logic file_wr_en,
    output logic [7:0] file_wdata,
    // accumulator and status
    output logic [7:0] acc,
    output logic zero_flag,
    output logic zero_we,
    // sequencing
    output logic instr_taken,
    output logic instr_done
);

    // ****************************************
    // reset release and phase sequencing
    // ****************************************
    logic [1:0] rst_sync;
    logic srst_n;
    logic [3:0] phase_en;

    // async assert, two-flop release so every flop leaves reset together
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign srst_n = rst_sync[1];

    xid_phase_gen #(
        .CLKS_PER_PHASE(CLKS_PER_PHASE)
    ) u_phase (
        .sys_clk(sys_clk),
        .rst_n(srst_n),
        .phase_en(phase_en)
    );

    // ****************************************
    // decode and state
    // ****************************************
    typedef struct packed {
        xid_op_t op;
        logic dest;
        logic [6:0] addr;
        logic [7:0] literal;
        logic [7:0] operand;
        logic [7:0] result;
        logic [7:0] acc;
        logic zero;
    } xid_dp_t;

    xid_dp_t st;
    xid_dp_t next_st;
    logic [5:0] opc;
    logic issue_imm;
    logic issue_reg;

    assign opc = instr_word[13:8];
    // other opcodes are left to the rest of the core and ignored here
    // the phase-1 enable already stands in reset, so gate on the release
    assign issue_imm = srst_n && phase_en[0] && instr_valid &&
        (opc == XID_OPC_IMM);
    assign issue_reg = srst_n && phase_en[0] && instr_valid &&
        (opc == XID_OPC_REG);

    always_comb
    begin
        next_st = st;
        if (phase_en[0])
        begin
            next_st.op = issue_imm ? XID_OP_IMM :
                         issue_reg ? XID_OP_REG : XID_OP_NONE;
            next_st.dest = instr_word[XID_DEST_BIT];
            next_st.addr = instr_word[6:0];
            next_st.literal = instr_word[7:0];
        end
        // read phase picks register or literal
        if (phase_en[1])
        begin
            next_st.operand = (st.op == XID_OP_REG) ? file_rdata : st.literal;
        end
        if (phase_en[2])
        begin
            next_st.result = st.acc ^ st.operand;
        end
        // write phase; a register write leaves the accumulator alone
        if (phase_en[3])
        begin
            if (st.op == XID_OP_IMM || (st.op == XID_OP_REG && !st.dest))
            begin
                next_st.acc = st.result;
            end
            if (st.op != XID_OP_NONE)
            begin
                next_st.zero = (st.result == 8'h00);
            end
            next_st.op = XID_OP_NONE;
        end
    end

    always_ff @(posedge sys_clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            st.op <= XID_OP_NONE;
            st.dest <= 1'b0;
            st.addr <= 7'h00;
            st.literal <= 8'h00;
            st.operand <= 8'h00;
            st.result <= 8'h00;
            st.acc <= XID_ACC_RST;
            st.zero <= XID_ZERO_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // strobes are combinational on the phase; data comes from flops
    assign file_addr = st.addr;
    assign file_rd_en = phase_en[1] && (st.op == XID_OP_REG);
    assign file_wr_en = phase_en[3] && (st.op == XID_OP_REG) && st.dest;
    assign file_wdata = st.result;
    assign acc = st.acc;
    assign zero_flag = st.zero;
    assign zero_we = phase_en[3] && (st.op != XID_OP_NONE);
    assign instr_taken = issue_imm || issue_reg;
    assign instr_done = zero_we;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!srst_n);

    // phase spacing in clocks for the default phase width of one clock
    sequence seq_imm_issue;
        issue_imm && CLKS_PER_PHASE == 1;
    endsequence

    sequence seq_reg_issue;
        issue_reg && CLKS_PER_PHASE == 1;
    endsequence

    sequence seq_reg_to_acc;
        issue_reg && !instr_word[XID_DEST_BIT] && CLKS_PER_PHASE == 1;
    endsequence

    sequence seq_reg_to_file;
        issue_reg && instr_word[XID_DEST_BIT] && CLKS_PER_PHASE == 1;
    endsequence

    chk_imm_result: assert property (
        seq_imm_issue |-> ##4
            acc == ($past(acc, 4) ^ $past(instr_word[7:0], 4)))
        else $error("immediate xor result wrong");

    chk_reg_read: assert property (
        seq_reg_issue |=> file_rd_en && file_addr == $past(instr_word[6:0]))
        else $error("register operand not read at its address");

    chk_acc_dest: assert property (
        seq_reg_to_acc |-> ##3 !file_wr_en ##1
            acc == ($past(acc, 4) ^ $past(file_rdata, 3)))
        else $error("accumulator destination handled wrong");

    chk_file_dest: assert property (
        seq_reg_to_file |-> ##3
            file_wr_en && file_wdata == ($past(acc, 3) ^ $past(file_rdata, 2))
            ##1 acc == $past(acc, 4))
        else $error("file destination handled wrong");

    chk_one_cycle: assert property (
        (issue_imm || issue_reg) && CLKS_PER_PHASE == 1 |->
            !instr_done [*3] ##1 instr_done ##1 !instr_done)
        else $error("instruction does not finish in four phases");

    chk_zero_flag: assert property (
        instr_done |=> zero_flag == ($past(file_wdata) == 8'h00))
        else $error("zero flag not set from result");

    chk_zero_hold: assert property (
        !instr_done |=> $stable(zero_flag))
        else $error("zero flag changed outside a write phase");

    chk_no_stray_wr: assert property (
        file_wr_en |-> $past(issue_reg, 3) && $past(instr_word[7], 3))
        else $error("file write without a register-destination xor");

endmodule : xid_datapath

// ### xid_file_model.sv
// file register model on the far side of the datapath's file port
// assumes reads are combinational on file_addr while file_rd_en is high
`timescale 1ns/1ps
module xid_file_model
(
    // clock
    input wire logic sys_clk,
    // file port
    input wire logic [6:0] file_addr,
    input wire logic file_rd_en,
    output logic [7:0] file_rdata,
    input wire logic file_wr_en,
    input wire logic [7:0] file_wdata
);
    // ****************************************
    // storage and access
    // ****************************************
    logic [7:0] regs [0:127];
    logic [7:0] last = 8'h00;

    // addressed operand read
    // released bus shows the inverse, so a late sample cannot match by luck
    always_comb
    begin
        file_rdata = file_rd_en ? regs[file_addr] : ~last;
    end

    // write back to the addressed register
    always @(posedge sys_clk)
    begin
        if (file_rd_en)
            last <= regs[file_addr];
        if (file_wr_en)
            regs[file_addr] <= file_wdata;
    end
endmodule : xid_file_model

// ### xid_phase_gen.sv
// four-phase sequencer for one instruction cycle
// assumes an asynchronous active-low reset whose release is already aligned to sys_clk
`timescale 1ns/1ps
module xid_phase_gen
    import xid_pkg::*;
#(
    parameter int CLKS_PER_PHASE = XID_CLKS_PER_PHASE
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // phase enables, each one clock wide at its phase's last clock
    output logic [3:0] phase_en
);

    typedef struct packed {
        logic [7:0] div;
        logic [1:0] phase;
        logic [3:0] en;
    } xid_pg_t;

    xid_pg_t st;
    xid_pg_t next_st;

    // divider plus phase counter; the enable marks the phase's last clock
    always_comb
    begin
        next_st = st;
        next_st.en = 4'h0;
        if (st.div == 8'(CLKS_PER_PHASE - 1))
        begin
            next_st.div = 8'h00;
            next_st.phase = st.phase + 2'h1;
        end
        else
        begin
            next_st.div = st.div + 8'h01;
        end
        if (next_st.div == 8'(CLKS_PER_PHASE - 1))
        begin
            next_st.en[next_st.phase] = 1'b1;
        end
    end

    // first phase enable is loaded by reset, ahead of the first edge, for one clock per phase
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st.div <= 8'h00;
            st.phase <= 2'h0;
            st.en <= (CLKS_PER_PHASE == 1) ? 4'h1 : 4'h0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign phase_en = st.en;

endmodule : xid_phase_gen

// ### xid_pkg.sv
// constants and types shared by the exclusive-OR datapath files
// assumes a 14-bit program word and an 8-bit data path
package xid_pkg;

    // ****************************************
    // widths and encodings
    // ****************************************
    localparam int XID_WORD_W = 14;
    localparam int XID_DATA_W = 8;
    localparam int XID_ADDR_W = 7;
    localparam int XID_OPC_W = 6;
    // opcode fields in bits 13:8 of the program word
    localparam logic [5:0] XID_OPC_IMM = 6'h3a;
    localparam logic [5:0] XID_OPC_REG = 6'h06;
    // destination bit position in the register form
    localparam int XID_DEST_BIT = 7;
    // reset value of the accumulator and the zero flag
    localparam logic [7:0] XID_ACC_RST = 8'h00;
    localparam logic XID_ZERO_RST = 1'b0;

    // ****************************************
    // timing
    // ****************************************
    localparam int XID_CLK_HZ = 20000000;
    // one instruction cycle, in nanoseconds
    localparam int XID_ICYC_NS = 200;
    localparam int XID_PHASES = 4;
    // system clocks per phase, derived from the rate
    localparam int XID_CLKS_PER_PHASE =
        (XID_ICYC_NS * (XID_CLK_HZ / 1000000)) / (1000 * XID_PHASES);

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        XID_OP_NONE = 2'b00,
        XID_OP_IMM = 2'b01,
        XID_OP_REG = 2'b10
    } xid_op_t;

endpackage : xid_pkg

// ### xor_instruction_datapath_test.sv
// self-checking bench for the exclusive-OR datapath
// assumes one phase per clock and the file model on the file port
`timescale 1ns/1ps
module xor_instruction_datapath_test
    import xid_pkg::*;
;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    logic [6:0] file_addr;
    logic file_rd_en, file_wr_en, zero_flag, zero_we;
    logic instr_taken, instr_done;
    logic [7:0] file_rdata, file_wdata, acc;
    int miscompares = 0;
    int n_checks = 0;

    // 50 ns period
    always #25 sys_clk = ~sys_clk;

    xid_datapath dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .file_addr(file_addr), .file_rd_en(file_rd_en),
        .file_rdata(file_rdata), .file_wr_en(file_wr_en),
        .file_wdata(file_wdata), .acc(acc), .zero_flag(zero_flag),
        .zero_we(zero_we), .instr_taken(instr_taken),
        .instr_done(instr_done));

    xid_file_model fm_u (.sys_clk(sys_clk), .file_addr(file_addr),
        .file_rd_en(file_rd_en), .file_rdata(file_rdata),
        .file_wr_en(file_wr_en), .file_wdata(file_wdata));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one instruction, checked at its issue, read and write phases and on the clock after the write
    task automatic run(input logic [13:0] w, input logic [7:0] ea,
        input logic ez, input logic ewr, input logic [7:0] ed);
        int n;
        logic rg;
        rg = (w[13:8] === XID_OPC_REG);
        n = 0;
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr_word = w;
        #1;
        while (instr_taken !== 1'b1 && n < 8)
        begin
            @(negedge sys_clk);
            #1;
            n++;
        end
        chk({7'h0, instr_taken}, 8'h01);
        @(negedge sys_clk);
        instr_valid = 1'b0;
        chk({7'h0, file_rd_en}, {7'h0, rg});
        if (rg)
            chk({1'b0, file_addr}, {1'b0, w[6:0]});
        repeat (2) @(negedge sys_clk);
        chk({6'h0, instr_done, zero_we}, 8'h03);
        chk({7'h0, file_wr_en}, {7'h0, ewr});
        if (ewr)
            chk(file_wdata, ed);
        @(negedge sys_clk);
        chk(acc, ea);
        chk({7'h0, zero_flag}, {7'h0, ez});
    endtask : run

    // ****************************************
    // scenarios
    // ****************************************
    // literal forms issued every other instruction cycle, including an all-zero result
    task automatic t_imm();
        run(14'h3ab5, 8'hb5, 1'b0, 1'b0, 8'h00);
        run(14'h3aaf, 8'h1a, 1'b0, 1'b0, 8'h00);
        run(14'h3a1a, 8'h00, 1'b1, 1'b0, 8'h00);
        run(14'h3aff, 8'hff, 1'b0, 1'b0, 8'h00);
        $display("test imm done");
    endtask : t_imm

    // register form into the accumulator, top and bottom address
    task automatic t_reg_acc();
        fm_u.regs[127] = 8'h0f;
        fm_u.regs[0] = 8'hf0;
        run(14'h067f, 8'hf0, 1'b0, 1'b0, 8'h00);
        chk(fm_u.regs[127], 8'h0f);
        run(14'h0600, 8'h00, 1'b1, 1'b0, 8'h00);
        $display("test reg_acc done");
    endtask : t_reg_acc

    // register form back into the file register
    task automatic t_reg_file();
        fm_u.regs[5] = 8'haf;
        fm_u.regs[6] = 8'hb5;
        run(14'h3ab5, 8'hb5, 1'b0, 1'b0, 8'h00);
        run(14'h0685, 8'hb5, 1'b0, 1'b1, 8'h1a);
        chk(fm_u.regs[5], 8'h1a);
        run(14'h0686, 8'hb5, 1'b1, 1'b1, 8'h00);
        $display("test reg_file done");
    endtask : t_reg_file

    // an offer made while reset is held must not be taken
    task automatic t_reset();
        repeat (3) @(negedge sys_clk);
        instr_valid = 1'b1;
        instr_word = 14'h3ab5;
        #1;
        chk({7'h0, instr_taken}, 8'h00);
        chk(acc, XID_ACC_RST);
        chk({7'h0, zero_flag}, {7'h0, XID_ZERO_RST});
        @(negedge sys_clk);
        instr_valid = 1'b0;
        $display("test reset done");
    endtask : t_reset

    // another opcode offered for two instruction cycles is ignored
    task automatic t_refuse();
        int hits;
        hits = 0;
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr_word = 14'h0e85;
        repeat (8)
        begin
            #1;
            if (instr_taken !== 1'b0 || file_wr_en !== 1'b0)
                hits++;
            @(negedge sys_clk);
        end
        instr_valid = 1'b0;
        chk(hits[7:0], 8'h00);
        chk(acc, 8'hb5);
        $display("test refuse done");
    endtask : t_refuse

    // ****************************************
    // run control
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // watchdog, far beyond the under 100 clocks the tests need
    initial
    begin
        #200000;
        miscompares++;
        wrap_up();
    end

    initial
    begin
        t_reset();
        @(negedge sys_clk);
        rst_n = 1'b1;
        t_imm();
        t_reg_acc();
        t_reg_file();
        t_refuse();
        wrap_up();
    end
endmodule : xor_instruction_datapath_test
